// ==== logic/pulse_train_consts.vh ====
// Constants for the pulse train profile generator.
`ifndef PULSE_TRAIN_CONSTS_VH
`define PULSE_TRAIN_CONSTS_VH
`define CLK_HZ 32'd200000000
`define MS_CYCLES (`CLK_HZ / 32'd1000)
`define NUM_PROFILES 7'd100
`define NUM_STEPS 5'd29
`define TABLE_WORDS 2900
`define RAMP_MS_DEFAULT 16'd1000
`define REG_CTRL 6'h00
`define REG_PROFILE 6'h04
`define REG_SS_FREQ 6'h08
`define REG_MAX_FREQ 6'h0c
`define REG_ACCEL_MS 6'h10
`define REG_DECEL_MS 6'h14
`define REG_TBL_INDEX 6'h18
`define REG_TBL_FREQ 6'h1c
`define REG_TBL_COUNT 6'h20
`define REG_TBL_HDR 6'h24
`define REG_STATUS 6'h28
`define REG_POSITION 6'h2c
`define CTRL_OUT_SEL 0
`define CTRL_COUNT_EN 1
`define CTRL_START 2
`define CTRL_ADVANCE 3
`define HDR_CONT 8
`define HDR_ADV_EN 9
`define ERR_NONE 8'h00
`define ERR_IMMEDIATE 8'h01
`define ERR_DECEL 8'h02
`define ERR_FORMAT 8'h03
`endif

// ==== logic/seq_divider.v ====
// Sequential restoring divider, one quotient bit per clock.
`timescale 1ns/10ps
`default_nettype none
module seq_divider (
   input wire mclk,
   input wire srst,
   input wire start,
   input wire [31:0] dividend,
   input wire [31:0] divisor,
   output reg busy,
   output reg done,
   output reg [31:0] quotient
);
   reg [31:0] rem;
   reg [31:0] quo;
   reg [31:0] dsr;
   reg [5:0] bitn;
   wire [32:0] trial = {rem[31:0], quo[31]} - {1'b0, dsr};
   always @(posedge mclk) begin
      if (srst) begin
         busy <= 1'b0;
         done <= 1'b0;
         quotient <= 32'h00000000;
         rem <= 32'h00000000;
         quo <= 32'h00000000;
         dsr <= 32'h00000000;
         bitn <= 6'h00;
      end else begin
         done <= 1'b0;
         if (!busy && start) begin
            busy <= 1'b1;
            rem <= 32'h00000000;
            quo <= dividend;
            dsr <= (divisor == 32'h00000000) ? 32'h00000001 : divisor;
            bitn <= 6'h20;
         end else if (busy) begin
            if (!trial[32]) begin
               rem <= trial[31:0];
               quo <= {quo[30:0], 1'b1};
            end else begin
               rem <= {rem[30:0], quo[31]};
               quo <= {quo[30:0], 1'b0};
            end
            bitn <= bitn - 6'h01;
            if (bitn == 6'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
               quotient <= trial[32] ? {quo[30:0], 1'b0} : {quo[30:0], 1'b1};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== logic/profile_table.v ====
// Profile storage: step records and one header per profile.
`timescale 1ns/10ps
`default_nettype none
`include "pulse_train_consts.vh"
module profile_table (
   input wire mclk,
   input wire we_step,
   input wire we_hdr,
   input wire [6:0] w_prof,
   input wire [4:0] w_step,
   input wire [23:0] w_freq,
   input wire [31:0] w_count,
   input wire [9:0] w_hdr,
   input wire [6:0] r_prof,
   input wire [4:0] r_step,
   output reg [23:0] r_freq,
   output reg [31:0] r_count,
   output reg [9:0] r_hdr,
   output reg [31:0] r_adv
);
   reg [23:0] freq_mem [0:`TABLE_WORDS-1];
   reg [31:0] count_mem [0:`TABLE_WORDS-1];
   reg [9:0] hdr_mem [0:`NUM_PROFILES-1];
   reg [31:0] adv_mem [0:`NUM_PROFILES-1];
   function [11:0] index;
      input [6:0] p;
      input [4:0] s;
      begin
         index = p * 12'd29 + {7'h00, s};
      end
   endfunction
   // Writes out of range are dropped so no record aliases another.
   wire w_ok = (w_prof < `NUM_PROFILES) && (w_step < `NUM_STEPS);
   wire r_ok = (r_prof < `NUM_PROFILES) && (r_step < `NUM_STEPS);
   always @(posedge mclk) begin
      if (we_step && w_ok) begin
         freq_mem[index(w_prof, w_step)] <= w_freq;
         count_mem[index(w_prof, w_step)] <= w_count;
      end
      if (we_hdr && w_prof < `NUM_PROFILES) begin
         hdr_mem[w_prof] <= w_hdr;
         adv_mem[w_prof] <= w_count;
      end
      r_freq <= r_ok ? freq_mem[index(r_prof, r_step)] : 24'h000000;
      r_count <= r_ok ? count_mem[index(r_prof, r_step)] : 32'h00000000;
      r_hdr <= (r_prof < `NUM_PROFILES) ? hdr_mem[r_prof] : 10'h000;
      r_adv <= (r_prof < `NUM_PROFILES) ? adv_mem[r_prof] : 32'h00000000;
   end
endmodule
`default_nettype wire

// ==== logic/pulse_train_generator.v ====
// Pulse train generator: register slave, profile engine and pulse output.
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "pulse_train_consts.vh"
module pulse_train_generator #(
   parameter [31:0] MS_TICKS = `MS_CYCLES
) (
   input wire mclk,
   input wire srst,
   input wire [5:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output wire waitrequest,
   input wire immediate_halt,
   input wire ramped_halt,
   output reg first_pulse_output,
   output reg second_pulse_output,
   output reg done,
   output reg [7:0] error_code
);
   localparam IDLE = 3'd0;
   localparam FETCH = 3'd1;
   localparam CHECK = 3'd2;
   localparam PREP = 3'd3;
   localparam RAMP = 3'd4;
   localparam RUN = 3'd5;
   localparam DECEL = 3'd6;
   localparam FINAL = 3'd7;

   reg ack;
   reg out_sel, count_en;
   reg [6:0] profile_sel, tbl_prof;
   reg [4:0] tbl_step;
   reg [23:0] ss_freq, max_freq, tbl_freq;
   reg [15:0] accel_ms, decel_ms;
   reg [31:0] tbl_count;
   reg [2:0] state;
   reg [6:0] cur_prof;
   reg [4:0] cur_step, nsteps;
   reg cont, adv_en, fetch_wait, rate_phase, rate_go, final_started, advancing;
   reg [23:0] freq, target, acc_rate, dec_rate;
   reg [31:0] remaining, position, ms_cnt, half_period, half_cnt, pulse_half;
   reg hp_valid, pulse_on, level;
   reg [1:0] ih_sync, rh_sync;

   wire bus_go = (read | write) & ~ack;
   assign waitrequest = (read | write) & ~ack;
   wire wr = write & ~ack;
   wire start_req = wr && address == `REG_CTRL && writedata[`CTRL_START];
   wire adv_req = wr && address == `REG_CTRL && writedata[`CTRL_ADVANCE];
   wire [23:0] m_freq;
   wire [31:0] m_count, m_adv, hp_q, rate_q;
   wire [9:0] m_hdr;
   wire hp_busy, hp_done, rate_busy, rate_done;
   wire ms_tick = (ms_cnt == MS_TICKS - 32'd1);
   wire gen_on = state >= RAMP;
   wire pulse_end = pulse_on && !level && half_cnt == 32'h00000000;
   wire want_more = gen_on && !final_started;
   wire halt_now = ih_sync[1] && state != IDLE;

   profile_table table_i (
      .mclk(mclk),
      .we_step(wr && address == `REG_TBL_COUNT),
      .we_hdr(wr && address == `REG_TBL_HDR),
      .w_prof(tbl_prof),
      .w_step(tbl_step),
      .w_freq(tbl_freq),
      .w_count((address == `REG_TBL_HDR) ? tbl_count : writedata),
      .w_hdr(writedata[9:0]),
      .r_prof(cur_prof),
      .r_step(cur_step),
      .r_freq(m_freq),
      .r_count(m_count),
      .r_hdr(m_hdr),
      .r_adv(m_adv)
   );

   // Half period recomputed continuously, so it lags freq by one division.
   seq_divider hp_div (
      .mclk(mclk),
      .srst(srst),
      .start(!hp_busy),
      .dividend(`CLK_HZ >> 1),
      .divisor({8'h00, freq}),
      .busy(hp_busy),
      .done(hp_done),
      .quotient(hp_q)
   );

   // ramp rate in Hz per millisecond
   seq_divider rate_div (
      .mclk(mclk),
      .srst(srst),
      .start(rate_go),
      .dividend({8'h00, max_freq - ss_freq}),
      .divisor({16'h0000, rate_phase ? decel_ms : accel_ms}),
      .busy(rate_busy),
      .done(rate_done),
      .quotient(rate_q)
   );

   always @(posedge mclk) begin
      if (srst) begin
         ack <= 1'b0;
         readdata <= 32'h00000000;
         out_sel <= 1'b0;
         count_en <= 1'b0;
         profile_sel <= 7'h00;
         ss_freq <= 24'h000000;
         max_freq <= 24'h000000;
         accel_ms <= `RAMP_MS_DEFAULT;
         decel_ms <= `RAMP_MS_DEFAULT;
         tbl_prof <= 7'h00;
         tbl_step <= 5'h00;
         tbl_freq <= 24'h000000;
         tbl_count <= 32'h00000000;
         ih_sync <= 2'b00;
         rh_sync <= 2'b00;
      end else begin
         ih_sync <= {ih_sync[0], immediate_halt};
         rh_sync <= {rh_sync[0], ramped_halt};
         ack <= bus_go;
         if (wr) begin
            case (address)
               `REG_CTRL: begin
                  out_sel <= writedata[`CTRL_OUT_SEL];
                  count_en <= writedata[`CTRL_COUNT_EN];
               end
               `REG_PROFILE: profile_sel <= writedata[6:0];
               `REG_SS_FREQ: ss_freq <= writedata[23:0];
               `REG_MAX_FREQ: max_freq <= writedata[23:0];
               `REG_ACCEL_MS: accel_ms <= writedata[15:0];
               `REG_DECEL_MS: decel_ms <= writedata[15:0];
               `REG_TBL_INDEX: begin
                  tbl_prof <= writedata[6:0];
                  tbl_step <= writedata[12:8];
               end
               `REG_TBL_FREQ: tbl_freq <= writedata[23:0];
               `REG_TBL_COUNT: tbl_count <= writedata;
               default: ;
            endcase
         end
         if (read && !ack) begin
            case (address)
               `REG_CTRL: readdata <= {30'h00000000, count_en, out_sel};
               `REG_PROFILE: readdata <= {25'h0000000, profile_sel};
               `REG_SS_FREQ: readdata <= {8'h00, ss_freq};
               `REG_MAX_FREQ: readdata <= {8'h00, max_freq};
               `REG_ACCEL_MS: readdata <= {16'h0000, accel_ms};
               `REG_DECEL_MS: readdata <= {16'h0000, decel_ms};
               `REG_TBL_INDEX: readdata <= {19'h00000, tbl_step, 1'b0, tbl_prof};
               `REG_TBL_FREQ: readdata <= {8'h00, tbl_freq};
               `REG_TBL_COUNT: readdata <= tbl_count;
               `REG_STATUS: readdata <= {3'h0, cur_step, 1'b0, cur_prof,
                                         error_code, 6'h00, done, state != IDLE};
               // position reads zero while the counter is off
               `REG_POSITION: readdata <= count_en ? position : 32'h00000000;
               default: readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Each half period is loaded at a boundary, so only an immediate halt can leave a runt pulse.
   always @(posedge mclk) begin
      if (srst || halt_now || !hp_valid) begin
         pulse_on <= 1'b0;
         level <= 1'b0;
         half_cnt <= 32'h00000000;
         half_period <= 32'h00000001;
         pulse_half <= 32'h00000001;
         hp_valid <= hp_valid && !srst;
         if (hp_done) begin
            hp_valid <= !srst;
            half_period <= hp_q;
         end
      end else begin
         if (hp_done) begin
            half_period <= (hp_q == 32'h00000000) ? 32'h00000001 : hp_q;
         end
         // The low half reuses the high half's length, so a divider result
         // arriving mid-pulse never splits one pulse unevenly.
         if (!pulse_on || pulse_end) begin
            pulse_on <= want_more;
            level <= want_more;
            half_cnt <= half_period - 32'd1;
            pulse_half <= half_period;
         end else if (half_cnt == 32'h00000000) begin
            level <= 1'b0;
            half_cnt <= pulse_half - 32'd1;
         end else begin
            half_cnt <= half_cnt - 32'd1;
         end
      end
   end

   // the selected output carries the train, the other stays low
   always @(posedge mclk) begin
      if (srst) begin
         first_pulse_output <= 1'b0;
         second_pulse_output <= 1'b0;
      end else begin
         first_pulse_output <= level && !out_sel && !halt_now;
         second_pulse_output <= level && out_sel && !halt_now;
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         state <= IDLE;
         done <= 1'b0;
         error_code <= `ERR_NONE;
         cur_prof <= 7'h00;
         cur_step <= 5'h00;
         nsteps <= 5'h00;
         cont <= 1'b0;
         adv_en <= 1'b0;
         fetch_wait <= 1'b0;
         rate_phase <= 1'b0;
         rate_go <= 1'b0;
         final_started <= 1'b0;
         advancing <= 1'b0;
         freq <= 24'h000000;
         target <= 24'h000000;
         acc_rate <= 24'h000000;
         dec_rate <= 24'h000000;
         remaining <= 32'h00000000;
         position <= 32'h00000000;
         ms_cnt <= 32'h00000000;
      end else begin
         rate_go <= 1'b0;
         fetch_wait <= 1'b0;
         ms_cnt <= ms_tick ? 32'h00000000 : ms_cnt + 32'd1;
         if (!count_en) begin
            position <= 32'h00000000;
         end else if (pulse_on && level && half_cnt == half_period - 32'd1 &&
                      state != IDLE) begin
            position <= position;
         end else if (pulse_end) begin
            position <= position + 32'd1;
         end
         if (pulse_end && state == FINAL) begin
            final_started <= 1'b1;
         end
         case (state)
            IDLE: begin
               final_started <= 1'b0;
               advancing <= 1'b0;
               // starts are honoured only when idle
               if (start_req) begin
                  done <= 1'b0;
                  cur_prof <= profile_sel;
                  cur_step <= 5'h00;
                  fetch_wait <= 1'b1;
                  state <= FETCH;
               end
            end
            FETCH: if (!fetch_wait) begin
               state <= CHECK;
            end
            CHECK: begin
               nsteps <= m_hdr[4:0];
               cont <= m_hdr[`HDR_CONT];
               adv_en <= m_hdr[`HDR_ADV_EN];
               remaining <= m_adv;
               if (cur_prof >= `NUM_PROFILES || m_hdr[4:0] == 5'h00 ||
                   m_hdr[4:0] > `NUM_STEPS || ss_freq == 24'h000000 ||
                   max_freq < ss_freq) begin
                  error_code <= `ERR_FORMAT;
                  done <= 1'b1;
                  state <= IDLE;
               end else begin
                  // every move starts at the start/stop frequency
                  freq <= ss_freq;
                  target <= m_freq;
                  rate_phase <= 1'b0;
                  rate_go <= 1'b1;
                  state <= PREP;
               end
            end
            PREP: begin
               if (rate_done) begin
                  rate_phase <= 1'b1;
                  rate_go <= !rate_phase;
                  if (!rate_phase) begin
                     acc_rate <= (rate_q[23:0] == 24'h000000) ? 24'h000001 : rate_q[23:0];
                  end else begin
                     dec_rate <= (rate_q[23:0] == 24'h000000) ? 24'h000001 : rate_q[23:0];
                  end
               end
               if (rate_phase && !rate_busy && !rate_go && hp_valid && freq == ss_freq) begin
                  ms_cnt <= 32'h00000000;
                  state <= RAMP;
               end
            end
            // linear ramp to the step target, one increment per ms
            RAMP: begin
               if (fetch_wait) begin
                  target <= m_freq;
               end else if (freq == target) begin
                  remaining <= m_count;
                  state <= RUN;
               end else if (ms_tick) begin
                  if (freq < target) begin
                     freq <= (target - freq > acc_rate) ? freq + acc_rate : target;
                  end else begin
                     freq <= (freq - target > dec_rate) ? freq - dec_rate : target;
                  end
               end
            end
            // constant segment of the step's pulse count
            RUN: begin
               // The step record lands one cycle after the index moves, so
               // the ramp takes its target one cycle later still.
               if (fetch_wait) begin
                  fetch_wait <= 1'b1;
                  state <= RAMP;
               end else if (cont && !advancing) begin
                  // advance: finish with the stored extra pulses
                  if (adv_req && adv_en) begin
                     advancing <= 1'b1;
                     remaining <= m_adv;
                  end
               end else if (remaining == 32'h00000000) begin
                  if (cur_step + 5'h01 < nsteps && !cont) begin
                     cur_step <= cur_step + 5'h01;
                     fetch_wait <= 1'b1;
                  end else begin
                     state <= DECEL;
                  end
               end else if (pulse_end) begin
                  remaining <= remaining - 32'd1;
               end
            end
            // final deceleration down to the start/stop frequency
            DECEL: begin
               if (freq <= ss_freq) begin
                  freq <= ss_freq;
                  state <= FINAL;
               end else if (ms_tick) begin
                  freq <= (freq - ss_freq > dec_rate) ? freq - dec_rate : ss_freq;
               end
            end
            // last pulse at start/stop speed, then the output rests
            FINAL: begin
               if (final_started && !pulse_on) begin
                  done <= 1'b1;
                  state <= IDLE;
               end
            end
            default: state <= IDLE;
         endcase
         // ramped halt decelerates whatever is running
         if (rh_sync[1] && (state == RAMP || state == RUN)) begin
            error_code <= `ERR_DECEL;
            state <= DECEL;
         end else if (state == CHECK && !(cur_prof >= `NUM_PROFILES ||
                      m_hdr[4:0] == 5'h00 || m_hdr[4:0] > `NUM_STEPS ||
                      ss_freq == 24'h000000 || max_freq < ss_freq)) begin
            error_code <= `ERR_NONE;
         end
         // immediate halt ends the move and posts its code
         if (halt_now) begin
            error_code <= `ERR_IMMEDIATE;
            done <= 1'b1;
            state <= IDLE;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/pt_gen_chk.sv ====
// Port assertions for the pulse train generator.
`timescale 1ns/10ps
`default_nettype none
module pt_gen_chk (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic immediate_halt,
   input wire logic ramped_halt,
   input wire logic first_pulse_output,
   input wire logic second_pulse_output,
   input wire logic done,
   input wire logic [7:0] error_code
);
   logic p;
   logic p_d;
   logic [15:0] hi_n;
   logic [15:0] lo_n;
   assign p = first_pulse_output | second_pulse_output;
   // The low run saturates so that idle gaps between moves never wrap.
   always_ff @(posedge mclk) begin
      if (srst) begin
         p_d <= 1'b0;
         hi_n <= 16'h0000;
         lo_n <= 16'h0000;
      end else begin
         p_d <= p;
         if (p && !p_d) hi_n <= 16'h0001;
         else if (p) hi_n <= hi_n + 16'h0001;
         if (!p && p_d) lo_n <= 16'h0001;
         else if (!p && lo_n != 16'hffff) lo_n <= lo_n + 16'h0001;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   wait_one_a: assert property ((read || write) && !$past(read) && !$past(write)
      |-> waitrequest ##1 !waitrequest) else $error("bus answer not after one wait");
   idle_wait_a: assert property (!read && !write |-> !waitrequest)
      else $error("wait raised with no request");
   one_output_a: assert property (!(first_pulse_output && second_pulse_output))
      else $error("both outputs pulsing");
   halt_quiet_a: assert property (immediate_halt [*5] |-> !p)
      else $error("pulses while halted");
   error_range_a: assert property (done |-> error_code <= 8'h03)
      else $error("bad completion code");
   unmapped_zero_a: assert property (read && !waitrequest && address >= 6'h30
      |-> readdata == 32'h0) else $error("unmapped read not zero");
   duty_equal_a: assert property (p && !p_d && lo_n < 16'd1000 |-> lo_n == hi_n)
      else $error("low phase differs from high phase");
   done_quiet_a: assert property (done && $past(done) |-> !p)
      else $error("pulse after completion");
   done_hold_a: assert property ($fell(done) |-> $past(write) || $past(write, 2))
      else $error("done cleared without a start");
endmodule
`default_nettype wire

// ==== verification/pulse_drive_model.sv ====
// Behavioural model of a drive step input that counts pulses.
`timescale 1ns/10ps
`default_nettype none
module pulse_drive_model (
   input wire logic mclk,
   input wire logic clr,
   input wire logic pulse,
   output var int count
);
   logic last = 1'b0;
   // The drive steps once on each rising edge of its input.
   always @(posedge mclk) begin
      last <= pulse;
      if (clr) count <= 0;
      else if (pulse && !last) count <= count + 1;
   end
endmodule
`default_nettype wire

// ==== verification/pulse_train_profile_generator_tb.sv ====
// Self-checking bench for the pulse train generator.
`timescale 1ns/10ps
`default_nettype none
`include "pulse_train_consts.vh"
module pulse_train_profile_generator_tb;
   typedef struct {string n; logic [31:0] e; logic [31:0] m;} note_t;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic read = 1'b0;
   logic write = 1'b0;
   logic immediate_halt = 1'b0;
   logic ramped_halt = 1'b0;
   logic clr = 1'b0;
   logic [5:0] address = 6'h00;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic first_pulse_output;
   logic second_pulse_output;
   logic done;
   logic [7:0] error_code;
   int cnt0;
   int cnt1;
   int err_count = 0;
   int n_compared = 0;
   note_t q[$];
   note_t t;
   pulse_train_generator #(.MS_TICKS(32'd50)) dut (.mclk(mclk), .srst(srst),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .immediate_halt(immediate_halt),
      .ramped_halt(ramped_halt), .first_pulse_output(first_pulse_output),
      .second_pulse_output(second_pulse_output), .done(done), .error_code(error_code));
   pulse_drive_model m0 (.mclk(mclk), .clr(clr), .pulse(first_pulse_output), .count(cnt0));
   pulse_drive_model m1 (.mclk(mclk), .clr(clr), .pulse(second_pulse_output), .count(cnt1));
   initial forever #2.5 mclk = ~mclk;
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Read results are matched against the oldest pending note.
   always @(posedge mclk) begin
      if (read && !waitrequest && q.size() > 0) begin
         t = q.pop_front();
         check(t.n, readdata & t.m, t.e & t.m);
      end
   end
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      @(posedge mclk iff !waitrequest);
      write <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      address <= a;
      read <= 1'b1;
      @(posedge mclk iff !waitrequest);
      d = readdata;
      read <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic chk(input string n, input logic [5:0] a, input logic [31:0] e,
      input logic [31:0] m);
      logic [31:0] d;
      q.push_back('{n, e, m});
      rd(a, d);
   endtask
   task automatic step_def(input int p, input int s, input int f, input int c);
      wr(`REG_TBL_INDEX, 32'(p) | (32'(s) << 8));
      wr(`REG_TBL_FREQ, 32'(f));
      wr(`REG_TBL_COUNT, 32'(c));
   endtask
   task automatic hdr_def(input int p, input logic [31:0] h);
      wr(`REG_TBL_INDEX, 32'(p));
      wr(`REG_TBL_HDR, h);
   endtask
   task automatic run(input int p, input logic [31:0] ctl);
      clr <= 1'b1;
      wr(`REG_PROFILE, 32'(p));
      clr <= 1'b0;
      wr(`REG_CTRL, ctl | 32'h4);
   endtask
   // Ends with a long idle gap so phase runs of separate moves never mix.
   task automatic wait_done;
      int k;
      k = 0;
      repeat (4) @(posedge mclk);
      while (done !== 1'b1 && k < 20000) begin
         @(negedge mclk);
         k++;
      end
      if (k == 20000) check("done wait", 32'h0, 32'h1);
      repeat (1200) @(posedge mclk);
   endtask
   initial begin
      #400000;
      err_count++;
      results;
   end
   initial begin
      int n;
      int c;
      int fmt[3];
      fmt = '{100, 4, 5};
      n = $urandom(32'h66903141);
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      chk("accel default", `REG_ACCEL_MS, 32'd1000, 32'hffff);
      chk("decel default", `REG_DECEL_MS, 32'd1000, 32'hffff);
      wr(6'h30, 32'hffffffff);
      chk("unmapped", 6'h30, 32'h0, 32'hffffffff);
      wr(`REG_SS_FREQ, 32'd5000000);
      wr(`REG_MAX_FREQ, 32'd10000000);
      wr(`REG_ACCEL_MS, 32'd2);
      wr(`REG_DECEL_MS, 32'd2);
      n = 20 + $urandom % 8;
      step_def(1, 0, 6000000 + $urandom % 4000000, n);
      hdr_def(1, 32'h1);
      step_def(2, 0, 7000000, 40);
      step_def(2, 1, 10000000, 400);
      hdr_def(2, 32'h2);
      step_def(99, 0, 10000000, 2);
      hdr_def(99, 32'h1);
      step_def(3, 0, 8000000, 4);
      hdr_def(3, 32'h301);
      hdr_def(4, 32'h0);
      hdr_def(5, 32'd30);
      foreach (fmt[i]) begin
         run(fmt[i], 32'h2);
         wait_done;
         chk("format status", `REG_STATUS, 32'h0302, 32'hff03);
      end
      run(1, 32'h2);
      repeat (200) @(posedge mclk);
      wr(`REG_CTRL, 32'h6);
      wait_done;
      chk("move status", `REG_STATUS, 32'h0002, 32'hff03);
      chk("position", `REG_POSITION, 32'(cnt0), 32'hffffffff);
      check("final pulses", 32'(cnt0 >= n + 1), 32'h1);
      check("no restart", 32'(cnt0 <= n + 13), 32'h1);
      check("unused output", 32'(cnt1), 32'h0);
      run(99, 32'h1);
      wait_done;
      chk("counter off", `REG_POSITION, 32'h0, 32'hffffffff);
      check("second pulses", 32'(cnt1 >= 3), 32'h1);
      check("first unused", 32'(cnt0), 32'h0);
      run(2, 32'h2);
      repeat (800) @(posedge mclk);
      immediate_halt <= 1'b1;
      repeat (6) @(posedge mclk);
      c = cnt0;
      wait_done;
      chk("halt status", `REG_STATUS, 32'h0102, 32'hff03);
      check("halt pulses", 32'(cnt0), 32'(c));
      immediate_halt <= 1'b0;
      repeat (10) @(posedge mclk);
      run(2, 32'h2);
      repeat (800) @(posedge mclk);
      ramped_halt <= 1'b1;
      repeat (6) @(posedge mclk);
      c = cnt0;
      wait_done;
      chk("ramp status", `REG_STATUS, 32'h0202, 32'hff03);
      check("ramp pulses", 32'(cnt0 > c), 32'h1);
      ramped_halt <= 1'b0;
      repeat (10) @(posedge mclk);
      // Turning the counter off clears the position left by the halted moves.
      wr(`REG_CTRL, 32'h0);
      run(3, 32'h2);
      repeat (600) @(posedge mclk);
      chk("rotating", `REG_STATUS, 32'h1, 32'h3);
      c = cnt0;
      wr(`REG_CTRL, 32'ha);
      wait_done;
      check("advance pulses", 32'(cnt0 >= c + 4 && cnt0 <= c + 14), 32'h1);
      chk("advance status", `REG_STATUS, 32'h0002, 32'hff03);
      chk("advance position", `REG_POSITION, 32'(cnt0), 32'hffffffff);
      results;
   end
endmodule
bind pulse_train_generator pt_gen_chk chk (.mclk(mclk), .srst(srst), .address(address),
   .read(read), .write(write), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .immediate_halt(immediate_halt), .ramped_halt(ramped_halt),
   .first_pulse_output(first_pulse_output), .second_pulse_output(second_pulse_output),
   .done(done), .error_code(error_code));
`default_nettype wire
